// >>> src/dai_i2c_writer.sv
// Purpose: i2c master that writes one byte triple (address, index, data)
// Assumes: open-drain pins, scl stretching honoured, 3-flop pin inputs
// Notes:   returns nack flag when any byte is not acknowledged
`timescale 1ns/10ps
`default_nettype none
module dai_i2c_writer #(
	parameter int QUARTER = dai_pkg::QUARTER_CYCLES
) (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       reset,
	// request
	input  wire logic       start,
	input  wire logic [7:0] dev_addr,
	input  wire logic [7:0] reg_index,
	input  wire logic [7:0] reg_data,
	output logic            busy,
	output logic            done,
	output logic            nack,
	// i2c pins
	input  wire logic       scl_in,
	output logic            scl_oe,
	input  wire logic       sda_in,
	output logic            sda_oe
);
	typedef enum {W_IDLE, W_START, W_BIT, W_ACK, W_STOP} dai_wst_t;
	// ==========================================================
	// pin synchronisers
	logic [2:0] scl_sync_reg;
	logic [2:0] sda_sync_reg;
	logic       scl_level_reg;
	logic       sda_level_reg;
	always_ff @(posedge mclk) begin
		if (reset) begin
			scl_sync_reg <= 3'h7;
			sda_sync_reg <= 3'h7;
		end else begin
			scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
			sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
		end
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			scl_level_reg <= 1'b1;
			sda_level_reg <= 1'b1;
		end else begin
			if (scl_sync_reg[1] == scl_sync_reg[2])
				scl_level_reg <= scl_sync_reg[2];
			if (sda_sync_reg[1] == sda_sync_reg[2])
				sda_level_reg <= sda_sync_reg[2];
		end
	end
	// ==========================================================
	// bit engine
	dai_wst_t    st_reg;
	logic [15:0] tick_reg;
	logic [1:0]  phase_reg;
	logic [2:0]  bit_reg;
	logic [1:0]  byte_reg;
	logic [7:0]  shift_reg;
	logic        nack_reg;
	logic        tick_end;
	logic        stretched;
	assign tick_end  = (tick_reg == 16'(QUARTER - 1));
	// scl is released for phase 3; a slow slave may hold it low, so wait there
	assign stretched = (phase_reg == 2'h3) && !scl_level_reg;
	assign busy      = (st_reg != W_IDLE);
	always_ff @(posedge mclk) begin
		if (reset) begin
			st_reg    <= W_IDLE;
			tick_reg  <= 16'h0000;
			phase_reg <= 2'h0;
			bit_reg   <= 3'h0;
			byte_reg  <= 2'h0;
			shift_reg <= 8'h00;
			nack_reg  <= 1'b0;
			scl_oe    <= 1'b0;
			sda_oe    <= 1'b0;
			done      <= 1'b0;
			nack      <= 1'b0;
		end else begin
			done <= 1'b0;
			if (st_reg == W_IDLE) begin
				tick_reg  <= 16'h0000;
				phase_reg <= 2'h0;
				if (start) begin
					st_reg    <= W_START;
					shift_reg <= dev_addr;
					byte_reg  <= 2'h0;
					bit_reg   <= 3'h7;
					nack_reg  <= 1'b0;
				end
			end else if (!tick_end || stretched) begin
				if (!stretched)
					tick_reg <= tick_reg + 16'h0001;
			end else begin
				tick_reg  <= 16'h0000;
				phase_reg <= phase_reg + 2'h1;
				case (phase_reg)
					2'h0: begin
						scl_oe <= (st_reg != W_START) || scl_oe;
						if (st_reg == W_STOP)
							sda_oe <= 1'b1;
					end
					2'h1: begin
						case (st_reg)
							// two quarters of free bus before start, two of start hold
							W_START: sda_oe <= 1'b1;
							W_BIT:   sda_oe <= !shift_reg[bit_reg];
							W_ACK:   sda_oe <= 1'b0;
							W_STOP:  sda_oe <= 1'b1;
							default: sda_oe <= sda_oe;
						endcase
					end
					2'h2: scl_oe <= 1'b0;
					default: begin
						case (st_reg)
							W_START: begin
								scl_oe <= 1'b1;
								st_reg <= W_BIT;
							end
							W_BIT: begin
								scl_oe <= 1'b1;
								bit_reg <= bit_reg - 3'h1;
								if (bit_reg == 3'h0)
									st_reg <= W_ACK;
							end
							W_ACK: begin
								scl_oe   <= 1'b1;
								nack_reg <= nack_reg || sda_level_reg;
								bit_reg  <= 3'h7;
								byte_reg <= byte_reg + 2'h1;
								shift_reg <= (byte_reg == 2'h0) ? reg_index : reg_data;
								// a refused byte ends the frame at once
								if (byte_reg == 2'h2 || sda_level_reg)
									st_reg <= W_STOP;
								else
									st_reg <= W_BIT;
							end
							W_STOP: begin
								sda_oe <= 1'b0;
								st_reg <= W_IDLE;
								done   <= 1'b1;
								nack   <= nack_reg;
							end
							default: st_reg <= W_IDLE;
						endcase
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// >>> inc/dai_pkg.sv
// Purpose: constants for the dual converter bring-up sequencer
// Assumes: 125 MHz mclk, standard-mode i2c
// Notes:   bus addresses are 8-bit write addresses (7-bit address shifted left)
package dai_pkg;
	// ==========================================================
	// bus addresses
	localparam logic [7:0] ADDR_MASTER_CONV = 8'h94;
	localparam logic [7:0] ADDR_SLAVE_CONV  = 8'h96;
	// ==========================================================
	// register offsets
	localparam logic [7:0] REG_PAGE_SELECT       = 8'h00;
	localparam logic [7:0] REG_GAIN_CH1_LEFT     = 8'h01;
	localparam logic [7:0] REG_GAIN_CH1_RIGHT    = 8'h02;
	localparam logic [7:0] REG_GAIN_CH2_LEFT     = 8'h03;
	localparam logic [7:0] REG_GAIN_CH2_RIGHT    = 8'h04;
	localparam logic [7:0] REG_GAIN_CONTROL      = 8'h05;
	localparam logic [7:0] REG_INSEL_CH1_LEFT    = 8'h06;
	localparam logic [7:0] REG_INSEL_CH1_RIGHT   = 8'h07;
	localparam logic [7:0] REG_INSEL_CH2_LEFT    = 8'h08;
	localparam logic [7:0] REG_INSEL_CH2_RIGHT   = 8'h09;
	localparam logic [7:0] REG_SECONDARY_INPUT   = 8'h0a;
	localparam logic [7:0] REG_SERIAL_FORMAT     = 8'h0b;
	localparam logic [7:0] REG_PIN0_FUNCTION     = 8'h10;
	localparam logic [7:0] REG_PIN3_FUNCTION     = 8'h11;
	localparam logic [7:0] REG_PIN0_DIRECTION    = 8'h12;
	localparam logic [7:0] REG_PIN3_DIRECTION    = 8'h13;
	localparam logic [7:0] REG_CLOCK_ROLE        = 8'h20;
	// ==========================================================
	// data values
	localparam logic [7:0] VAL_PAGE_ZERO         = 8'h00;
	localparam logic [7:0] VAL_GAIN_32DB         = 8'h40;
	localparam logic [7:0] VAL_GAIN_SMOOTH_INDEP = 8'h86;
	localparam logic [7:0] VAL_INPUT_ONE_SE      = 8'h41;
	localparam logic [7:0] VAL_INPUT_THREE_SE    = 8'h44;
	localparam logic [7:0] VAL_NO_SECONDARY      = 8'h00;
	localparam logic [7:0] VAL_I2S_24BIT         = 8'h44;
	localparam logic [7:0] VAL_PIN0_BCLK_OUT     = 8'h03;
	localparam logic [7:0] VAL_PIN0_GPIO         = 8'h00;
	localparam logic [7:0] VAL_PIN0_DIR_OUT      = 8'h04;
	localparam logic [7:0] VAL_PIN0_DIR_IN       = 8'h00;
	localparam logic [7:0] VAL_PIN3_DATA2        = 8'h50;
	localparam logic [7:0] VAL_PIN3_DIR_OUT      = 8'h40;
	localparam logic [7:0] VAL_ROLE_MASTER       = 8'h11;
	localparam logic [7:0] VAL_ROLE_SLAVE        = 8'h01;
	// ==========================================================
	// sequence shape
	localparam int         STEPS_PER_CONV = 17;
	localparam logic [4:0] LAST_STEP      = 5'h10;
	// ==========================================================
	// i2c timing: standard mode, 10 us bit period
	localparam int         MCLK_HZ         = 125_000_000;
	localparam int         I2C_HZ          = 100_000;
	localparam int         QUARTER_CYCLES  = MCLK_HZ / (I2C_HZ * 4);
	localparam int         RETRY_LIMIT     = 3;
endpackage

// >>> src/dai_init_sequencer.sv
// Purpose: host-side bring-up of two four-channel converters over i2c
// Assumes: board hardware ready is signalled on hw_ready by other logic
// Notes:   master converter first, then slave; each write retried on nack
// ==========================================================
// Behaviour
// RQ1: the first converter is written at bus address 0x94 and set up as clock master.
// RQ2: the second converter is written at bus address 0x96 and set up as clock slave.
// RQ3: configuration starts only once hardware setup is done and uses only i2c writes.
// RQ4: each converter's first write puts 0x00 in register 0x00 to select page zero.
// RQ5: registers 0x01 to 0x04 each get 0x40 for 32dB channel gain.
// RQ6: register 0x05 gets 0x86 for smooth, independent gain changes.
// RQ7: registers 0x06 and 0x07 get 0x41 to route input one left and right.
// RQ8: registers 0x08 and 0x09 get 0x44 to route input three left and right.
// RQ9: register 0x0A gets 0x00 so no secondary input is selected.
// RQ10: register 0x0B gets 0x44 for 24-bit words in i2s framing.
// RQ11: the master gets 0x03 in 0x10 and 0x04 in 0x12 so pin zero drives the bit clock.
// RQ12: the slave gets 0x00 in 0x10 and 0x12 so pin zero stays a plain input.
// RQ13: both converters get 0x50 in 0x11 and 0x40 in 0x13 for second data out on pin three.
// RQ14: the master gets 0x11 in 0x20 for master role with clock detection off.
// RQ15: the slave gets 0x01 in 0x20 for slave role with clock detection on.
// RQ16: each step is one write of index then data, in order, waiting for acknowledge.
// RQ17: the slave takes its clocks from the master so both streams stay frame aligned.
`timescale 1ns/10ps
`default_nettype none
module dai_init_sequencer #(
	parameter int QUARTER     = dai_pkg::QUARTER_CYCLES,
	parameter int RETRY_LIMIT = dai_pkg::RETRY_LIMIT
) (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       reset,
	// user side
	input  wire logic       hw_ready,
	input  wire logic       go,
	output logic            config_busy,
	output logic            config_done,
	output logic            config_error,
	output logic [4:0]      step_index,
	output logic            conv_select,
	// i2c pins
	input  wire logic       scl_in,
	output logic            scl_out,
	output logic            scl_oe,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe
);
	typedef enum {S_IDLE, S_WAIT_HW, S_ISSUE, S_WAIT, S_DONE, S_FAIL} dai_sst_t;
	// ==========================================================
	// open drain: only ever pull low
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	// ==========================================================
	// table lookup of one configuration step
	function automatic logic [15:0] step_word(input logic slave, input logic [4:0] idx);
		logic [15:0] w;
		w = {dai_pkg::REG_PAGE_SELECT, dai_pkg::VAL_PAGE_ZERO};
		case (idx)
			// RQ4: page zero first
			5'h00: w = {dai_pkg::REG_PAGE_SELECT, dai_pkg::VAL_PAGE_ZERO};
			// RQ5: channel gain
			5'h01: w = {dai_pkg::REG_GAIN_CH1_LEFT, dai_pkg::VAL_GAIN_32DB};
			5'h02: w = {dai_pkg::REG_GAIN_CH1_RIGHT, dai_pkg::VAL_GAIN_32DB};
			5'h03: w = {dai_pkg::REG_GAIN_CH2_LEFT, dai_pkg::VAL_GAIN_32DB};
			5'h04: w = {dai_pkg::REG_GAIN_CH2_RIGHT, dai_pkg::VAL_GAIN_32DB};
			// RQ6: smooth independent gain
			5'h05: w = {dai_pkg::REG_GAIN_CONTROL, dai_pkg::VAL_GAIN_SMOOTH_INDEP};
			// RQ7: input one routing
			5'h06: w = {dai_pkg::REG_INSEL_CH1_LEFT, dai_pkg::VAL_INPUT_ONE_SE};
			5'h07: w = {dai_pkg::REG_INSEL_CH1_RIGHT, dai_pkg::VAL_INPUT_ONE_SE};
			// RQ8: input three routing
			5'h08: w = {dai_pkg::REG_INSEL_CH2_LEFT, dai_pkg::VAL_INPUT_THREE_SE};
			5'h09: w = {dai_pkg::REG_INSEL_CH2_RIGHT, dai_pkg::VAL_INPUT_THREE_SE};
			// RQ9: no secondary input
			5'h0a: w = {dai_pkg::REG_SECONDARY_INPUT, dai_pkg::VAL_NO_SECONDARY};
			// RQ10: 24-bit i2s
			5'h0b: w = {dai_pkg::REG_SERIAL_FORMAT, dai_pkg::VAL_I2S_24BIT};
			// RQ11 RQ12: pin zero role
			5'h0c: w = {dai_pkg::REG_PIN0_FUNCTION,
				slave ? dai_pkg::VAL_PIN0_GPIO : dai_pkg::VAL_PIN0_BCLK_OUT};
			// RQ13: pin three second data
			5'h0d: w = {dai_pkg::REG_PIN3_FUNCTION, dai_pkg::VAL_PIN3_DATA2};
			// RQ11 RQ12: pin zero direction
			5'h0e: w = {dai_pkg::REG_PIN0_DIRECTION,
				slave ? dai_pkg::VAL_PIN0_DIR_IN : dai_pkg::VAL_PIN0_DIR_OUT};
			// RQ13: pin three direction
			5'h0f: w = {dai_pkg::REG_PIN3_DIRECTION, dai_pkg::VAL_PIN3_DIR_OUT};
			// RQ14 RQ15 RQ17: clock role, slave follows master clocks
			5'h10: w = {dai_pkg::REG_CLOCK_ROLE,
				slave ? dai_pkg::VAL_ROLE_SLAVE : dai_pkg::VAL_ROLE_MASTER};
			default: w = {dai_pkg::REG_PAGE_SELECT, dai_pkg::VAL_PAGE_ZERO};
		endcase
		return w;
	endfunction
	// ==========================================================
	// sequencer
	dai_sst_t    state_reg;
	logic [4:0]  step_reg;
	logic        slave_reg;
	logic [1:0]  retry_reg;
	logic        wr_start;
	logic        wr_busy;
	logic        wr_done;
	logic        wr_nack;
	logic [7:0]  dev_addr;
	logic [15:0] cur_word;
	// RQ1 RQ2: converter bus address
	assign dev_addr = slave_reg ? dai_pkg::ADDR_SLAVE_CONV : dai_pkg::ADDR_MASTER_CONV;
	assign cur_word = step_word(slave_reg, step_reg);
	assign wr_start = (state_reg == S_ISSUE) && !wr_busy;
	assign config_busy  = (state_reg != S_IDLE) && (state_reg != S_DONE)
		&& (state_reg != S_FAIL);
	assign config_done  = (state_reg == S_DONE);
	assign config_error = (state_reg == S_FAIL);
	assign step_index   = step_reg;
	assign conv_select  = slave_reg;
	always_ff @(posedge mclk) begin
		if (reset) begin
			state_reg <= S_IDLE;
			step_reg  <= 5'h00;
			slave_reg <= 1'b0;
			retry_reg <= 2'h0;
		end else begin
			case (state_reg)
				S_IDLE, S_DONE, S_FAIL: begin
					if (go) begin
						state_reg <= S_WAIT_HW;
						step_reg  <= 5'h00;
						slave_reg <= 1'b0;
						retry_reg <= 2'h0;
					end
				end
				// RQ3: hold off until hardware ready
				S_WAIT_HW: begin
					if (hw_ready)
						state_reg <= S_ISSUE;
				end
				S_ISSUE: begin
					if (!wr_busy)
						state_reg <= S_WAIT;
				end
				// RQ16: advance only after acknowledge
				S_WAIT: begin
					if (wr_done) begin
						if (wr_nack) begin
							retry_reg <= retry_reg + 2'h1;
							state_reg <= (retry_reg == 2'(RETRY_LIMIT - 1)) ? S_FAIL : S_ISSUE;
						end else begin
							retry_reg <= 2'h0;
							if (step_reg != dai_pkg::LAST_STEP) begin
								step_reg  <= step_reg + 5'h01;
								state_reg <= S_ISSUE;
							end else if (!slave_reg) begin
								// master is clocking before the slave is told to follow
								slave_reg <= 1'b1;
								step_reg  <= 5'h00;
								state_reg <= S_ISSUE;
							end else begin
								state_reg <= S_DONE;
							end
						end
					end
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end
	// ==========================================================
	// RQ16: index then data in one write
	dai_i2c_writer #(
		.QUARTER (QUARTER)
	) u_writer (
		.mclk      (mclk),
		.reset     (reset),
		.start     (wr_start),
		.dev_addr  (dev_addr),
		.reg_index (cur_word[15:8]),
		.reg_data  (cur_word[7:0]),
		.busy      (wr_busy),
		.done      (wr_done),
		.nack      (wr_nack),
		.scl_in    (scl_in),
		.scl_oe    (scl_oe),
		.sda_in    (sda_in),
		.sda_oe    (sda_oe)
	);
endmodule
`default_nettype wire

// >>> sim/dai_seq_checker.sv
// Purpose: port-level checks for the bring-up sequencer
// Assumes: one mclk domain, synchronous reset
// Notes:   bound to every sequencer instance
`timescale 1ns/10ps
`default_nettype none
module dai_seq_checker #(
	parameter int QUARTER     = 4,
	parameter int RETRY_LIMIT = 3
) (
	// clock and reset
	input wire logic       mclk,
	input wire logic       reset,
	// user side
	input wire logic       hw_ready,
	input wire logic       go,
	input wire logic       config_busy,
	input wire logic       config_done,
	input wire logic       config_error,
	input wire logic [4:0] step_index,
	input wire logic       conv_select,
	// i2c pins
	input wire logic       scl_in,
	input wire logic       scl_out,
	input wire logic       scl_oe,
	input wire logic       sda_in,
	input wire logic       sda_out,
	input wire logic       sda_oe
);
	default clocking cb_main @(posedge mclk); endclocking
	default disable iff (reset);
	// ==========================================================
	// first frame tracker
	logic first_frame;
	always_ff @(posedge mclk) begin
		if (reset) begin
			first_frame <= 1'b0;
		end else if ($rose(config_busy)) begin
			first_frame <= 1'b1;
		end else if ($rose(sda_oe)) begin
			first_frame <= 1'b0;
		end
	end
	// ==========================================================
	// properties
	busy_on_go_a: assert property (go && !config_busy |=> config_busy)
		else $error("busy did not follow go");
	idle_quiet_a: assert property (!config_busy && !$past(config_busy) |-> !scl_oe && !sda_oe)
		else $error("bus driven while idle");
	wait_ready_a: assert property (config_busy && !hw_ready |-> !sda_oe && !scl_oe)
		else $error("bus driven before hardware ready");
	page_first_a: assert property ($rose(sda_oe) && first_frame |-> step_index == 5'h00 && !conv_select)
		else $error("first frame not page select of master");
	step_order_a: assert property (config_busy && $past(config_busy) && $changed(step_index)
		|-> step_index == $past(step_index) + 5'h01
		|| (step_index == 5'h00 && $past(step_index) == dai_pkg::LAST_STEP))
		else $error("step order broken");
	done_last_a: assert property ($rose(config_done) |-> $past(conv_select)
		&& $past(step_index) == dai_pkg::LAST_STEP)
		else $error("done before last slave step");
	flags_excl_a: assert property (!(config_done && config_error) && !(config_busy && config_done))
		else $error("status flags overlap");
	open_drain_a: assert property (scl_out == 1'b0 && sda_out == 1'b0 && step_index <= 5'h10)
		else $error("line driven high or step out of range");
endmodule
bind dai_init_sequencer dai_seq_checker #(.QUARTER(QUARTER), .RETRY_LIMIT(RETRY_LIMIT)) i_chk (
	.mclk(mclk), .reset(reset), .hw_ready(hw_ready), .go(go), .config_busy(config_busy),
	.config_done(config_done), .config_error(config_error), .step_index(step_index),
	.conv_select(conv_select), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));
`default_nettype wire

// >>> sim/dai_conv_model.sv
// Purpose: behavioural pair of converters on one i2c bus
// Assumes: lines pulled up, host is the only master
// Notes:   nacks on bench request, unknown address or a fourth byte; clock stretching only on bench request
`timescale 1ns/10ps
`default_nettype none
module dai_conv_model (
	// bus lines
	input  wire logic scl,
	input  wire logic sda,
	output logic      scl_hold,
	output logic      sda_hold,
	// fault controls
	input  wire logic refuse,
	input  wire logic stretch
);
	logic [7:0] regs [0:1][0:255];
	logic [7:0] log_a [0:63];
	logic [7:0] log_i [0:63];
	logic [7:0] log_d [0:63];
	logic [7:0] shift, addr_b, idx_b;
	logic       on, ack_ph, ok;
	int         bits, bytes;
	int         log_n = 0;
	int         attempts = 0;
	initial {scl_hold, sda_hold, on, ack_ph} = 4'h0;
	// ==========================================================
	// frame edges
	always @(negedge sda) begin
		if (scl) begin
			on = 1'b1;
			bits = 0;
			bytes = 0;
		end
	end
	always @(posedge sda) if (scl) on = 1'b0;
	always @(posedge scl) begin
		if (on && !ack_ph) begin
			shift = {shift[6:0], sda};
			bits++;
		end
	end
	// ==========================================================
	// acknowledge and store
	always @(negedge scl) begin
		if (ack_ph) begin
			ack_ph = 1'b0;
			sda_hold = 1'b0;
			bits = 0;
			// slow answer: the host must wait out the low clock
			if (stretch) begin
				scl_hold = 1'b1;
				#200 scl_hold = 1'b0;
			end
		end else if (on && bits == 8) begin
			ack_ph = 1'b1;
			ok = bytes < 3;
			if (bytes == 0) begin
				attempts++;
				addr_b = shift;
				ok = !refuse && (shift == 8'h94 || shift == 8'h96);
			end
			if (bytes == 1) idx_b = shift;
			if (bytes == 2) begin
				regs[addr_b[1]][idx_b] = shift;
				if (log_n < 64) begin
					log_a[log_n] = addr_b;
					log_i[log_n] = idx_b;
					log_d[log_n] = shift;
					log_n++;
				end
			end
			bytes++;
			sda_hold = ok;
		end
	end
endmodule
`default_nettype wire

// >>> sim/dual_adc_i2c_init_sequencer_tb_top.sv
// Purpose: self-checking bench for the bring-up sequencer
// Assumes: QUARTER of 4 keeps each full 34-write run near 20k cycles
// Notes:   expected writes come from the fixed tables below
`timescale 1ns/10ps
`default_nettype none
module dual_adc_i2c_init_sequencer_tb_top;
	logic mclk, reset, hw_ready, go, refuse, stretch;
	wire logic busy, done, fail, conv, scl_oe, sda_oe, scl_hold, sda_hold;
	wire logic [4:0] step;
	int errors = 0;
	int checks = 0;
	int cycles = 0;
	logic [7:0] idx_t [0:16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
		8'h08, 8'h09, 8'h0a, 8'h0b, 8'h10, 8'h11, 8'h12, 8'h13, 8'h20};
	logic [7:0] mdat_t [0:16] = '{8'h00, 8'h40, 8'h40, 8'h40, 8'h40, 8'h86, 8'h41, 8'h41,
		8'h44, 8'h44, 8'h00, 8'h44, 8'h03, 8'h50, 8'h04, 8'h40, 8'h11};
	logic [7:0] sdat_t [0:16] = '{8'h00, 8'h40, 8'h40, 8'h40, 8'h40, 8'h86, 8'h41, 8'h41,
		8'h44, 8'h44, 8'h00, 8'h44, 8'h00, 8'h50, 8'h00, 8'h40, 8'h01};
	// pull-ups: a line is low while anyone pulls it
	wire logic scl_w = !(scl_oe | scl_hold);
	wire logic sda_w = !(sda_oe | sda_hold);
	dai_init_sequencer #(.QUARTER(4), .RETRY_LIMIT(3)) i_dut (
		.mclk(mclk), .reset(reset), .hw_ready(hw_ready), .go(go), .config_busy(busy),
		.config_done(done), .config_error(fail), .step_index(step), .conv_select(conv),
		.scl_in(scl_w), .scl_out(), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe));
	dai_conv_model i_model (.scl(scl_w), .sda(sda_w), .scl_hold(scl_hold),
		.sda_hold(sda_hold), .refuse(refuse), .stretch(stretch));
	always #4 mclk = ~mclk;
	// ==========================================================
	// shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic pulse_go();
		i_model.log_n = 0;
		i_model.attempts = 0;
		@(negedge mclk) go = 1'b1;
		@(negedge mclk) go = 1'b0;
		repeat (2) @(negedge mclk);
	endtask
	task automatic wait_end();
		for (int n = 0; n < 30000 && done !== 1'b1 && fail !== 1'b1; n++) @(negedge mclk);
	endtask
	task automatic check_log();
		check(i_model.log_n, 34);
		for (int k = 0; k < 34; k++) begin
			check(i_model.log_a[k], k < 17 ? 8'h94 : 8'h96);
			check(i_model.log_i[k], idx_t[k % 17]);
			check(i_model.log_d[k], k < 17 ? mdat_t[k] : sdat_t[k - 17]);
		end
	endtask
	// ==========================================================
	// scenarios
	task automatic t_wait_ready();
		pulse_go();
		repeat (300) @(negedge mclk);
		check(i_model.attempts, 0);
		check(busy, 1'b1);
		hw_ready = 1'b1;
		wait_end();
		check({done, fail}, 2'b10);
		check({conv, step}, 6'h30);
		check(i_model.regs[0][8'h20], 8'h11);
		check(i_model.regs[1][8'h20], 8'h01);
		check_log();
	endtask
	task automatic t_retry_ok();
		refuse = 1'b1;
		pulse_go();
		check(done, 1'b0);
		for (int n = 0; n < 5000 && i_model.attempts < 2; n++) @(negedge mclk);
		refuse = 1'b0;
		wait_end();
		check({done, fail}, 2'b10);
		check(i_model.attempts, 36);
		check_log();
	endtask
	task automatic t_slow_ignore_go();
		stretch = 1'b1;
		pulse_go();
		repeat (2000) @(negedge mclk);
		@(negedge mclk) go = 1'b1;
		@(negedge mclk) go = 1'b0;
		wait_end();
		stretch = 1'b0;
		check({done, fail}, 2'b10);
		check(i_model.attempts, 34);
		check_log();
	endtask
	task automatic t_give_up();
		refuse = 1'b1;
		pulse_go();
		wait_end();
		refuse = 1'b0;
		check({done, fail}, 2'b01);
		check({conv, step}, 6'h00);
		check(i_model.attempts, 3);
		check(i_model.log_n, 0);
	endtask
	// ==========================================================
	// run-time ceiling
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 95000) begin
			errors++;
			stop_test();
		end
	end
	initial begin
		{mclk, reset, hw_ready, go, refuse, stretch} = 6'b010000;
		repeat (4) @(negedge mclk);
		reset = 1'b0;
		t_wait_ready();
		t_retry_ok();
		t_slow_ignore_go();
		t_give_up();
		stop_test();
	end
endmodule
`default_nettype wire
